// [pkg/irq_phy_regs_pkg.sv]
// constants and types for the socket-less interrupt and phy register group
// Behaviour
// - one written to common clear drops flag
// - socket mask bit n enables socket n
// - socket-less mask enables each socket-less flag
// - one written to socket-less clear drops flag
// - auto source follows destination address scope
// - code 02 link-local, code 03 global source
// - command bit sends packet, self-clears when done
// - command bits six to zero select packets
// - command outcome reported only through flags
// - status bits five to three show mode
// - status bit two half duplex when up
// - status bit one ten megabit when up
// - bit seven unplugged, bit zero link up
// - five-bit phy register address, upper reserved
// - sixteen-bit write data, low byte first
// - access code 01 writes, 02 reads, self-clears
// - read data captures addressed phy register
// - timeout flag set when no reply
package irq_phy_regs_pkg;
  localparam logic [15:0] ADDR_COMMON_IRQ_CLEAR = 16'h2108;
  localparam logic [15:0] ADDR_SOCKET_IRQ_MASK = 16'h2114;
  localparam logic [15:0] ADDR_SOCKLESS_IRQ_MASK = 16'h2124;
  localparam logic [15:0] ADDR_SOCKLESS_IRQ_CLEAR = 16'h2128;
  localparam logic [15:0] ADDR_SOURCE_SELECT = 16'h212c;
  localparam logic [15:0] ADDR_SOCKLESS_COMMAND = 16'h2130;
  localparam logic [15:0] ADDR_PHY_STATUS = 16'h3000;
  localparam logic [15:0] ADDR_PHY_REG_ADDRESS = 16'h3008;
  localparam logic [15:0] ADDR_PHY_WRITE_DATA_LO = 16'h300c;
  localparam logic [15:0] ADDR_PHY_WRITE_DATA_HI = 16'h300d;
  localparam logic [15:0] ADDR_PHY_READ_DATA_LO = 16'h3010;
  localparam logic [15:0] ADDR_PHY_READ_DATA_HI = 16'h3011;
  localparam logic [15:0] ADDR_PHY_ACCESS_CONTROL = 16'h3014;
  localparam logic [7:0] COMMON_FLAG_BITS = 8'h97;
  localparam logic [7:0] COMMAND_BITS = 8'h7f;
  localparam logic [7:0] REPLY_COMMAND_BITS = 8'h7e;
  localparam logic [7:0] TIMEOUT_FLAG = 8'h80;
  localparam logic [7:0] RA_FLAG = 8'h01;
  localparam logic [7:0] SRC_AUTO = 8'h00;
  localparam logic [7:0] SRC_LINK_LOCAL = 8'h02;
  localparam logic [7:0] SRC_GLOBAL = 8'h03;
  localparam logic [7:0] PHY_ACC_WRITE = 8'h01;
  localparam logic [7:0] PHY_ACC_READ = 8'h02;
  localparam int PHY_ADDR_W = 5;
  localparam int PIN_UNPLUGGED = 3;
  localparam int PIN_HALF_DUPLEX = 2;
  localparam int PIN_SPEED10 = 1;
  localparam int PIN_LINK_UP = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [3:0] RST_PINS = 4'h0;
  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_BUSY = 1'b1
  } seq_state_t;
endpackage : irq_phy_regs_pkg

// [hdl/irq_sockless_phy_regs.sv]
// socket-less interrupt, command, source select and phy access register group
`timescale 1ns/1ps
module irq_sockless_phy_regs
  import irq_phy_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata_r,
  input wire logic [7:0] common_event,
  input wire logic [7:0] common_irq_mask,
  input wire logic [7:0] socket_interrupt_summary,
  input wire logic cmd_done,
  input wire logic cmd_reply_ok,
  input wire logic ra_received,
  input wire logic dest_is_link_local,
  input wire logic [3:0] phy_pins,
  input wire logic [2:0] phy_mode,
  input wire logic mgmt_done,
  input wire logic [15:0] mgmt_rdata,
  output logic [7:0] common_interrupt_flags_r,
  output logic [7:0] sockless_interrupt_flags_r,
  output logic [7:0] sockless_command_r,
  output logic cmd_go_r,
  output logic use_global_src_r,
  output logic mgmt_go_r,
  output logic mgmt_write_r,
  output logic [PHY_ADDR_W-1:0] mgmt_addr_r,
  output logic [15:0] mgmt_wdata_r,
  output logic irq_r
);

  function automatic logic wr_to(input logic [15:0] a);
    wr_to = bus_wr && (bus_addr == a);
  endfunction : wr_to

  // set term is or-ed last so an event in the clearing cycle survives
  function automatic logic [7:0] w1c_next(input logic [7:0] flags, input logic [7:0] set,
                                          input logic [7:0] clr);
    w1c_next = (flags & ~clr) | set;
  endfunction : w1c_next

  logic [7:0] socket_irq_mask_r;
  logic [7:0] sockless_irq_mask_r;
  logic [7:0] source_select_r;
  logic [7:0] phy_access_control_r;
  logic [15:0] phy_read_data_r;
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  seq_state_t cmd_state_r;
  seq_state_t acc_state_r;
  logic [7:0] common_set;
  logic [7:0] common_clr;
  logic [7:0] sockless_set;
  logic [7:0] sockless_clr;
  logic [7:0] phy_status;
  logic [7:0] rd_nxt;
  logic cmd_accept;
  logic cmd_finish;
  logic acc_accept;
  logic acc_finish;
  logic irq_nxt;

  // hardware-set / software-clear flags
  always_comb begin
    common_set = common_event & COMMON_FLAG_BITS;
    common_clr = wr_to(ADDR_COMMON_IRQ_CLEAR) ? (bus_wdata & COMMON_FLAG_BITS) : RST_BYTE;
    sockless_clr = wr_to(ADDR_SOCKLESS_IRQ_CLEAR) ? bus_wdata : RST_BYTE;
    sockless_set = ra_received ? RA_FLAG : RST_BYTE;
    if (cmd_finish) begin
      // outcome shows only here: reply flag for command bits six to one on success, timeout otherwise
      if (cmd_reply_ok) begin
        sockless_set = sockless_set | (sockless_command_r & REPLY_COMMAND_BITS);
      end else begin
        sockless_set = sockless_set | TIMEOUT_FLAG;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      common_interrupt_flags_r <= RST_BYTE;
      sockless_interrupt_flags_r <= RST_BYTE;
    end else if (ce) begin
      common_interrupt_flags_r <= w1c_next(common_interrupt_flags_r, common_set,
                                           common_clr);
      sockless_interrupt_flags_r <= w1c_next(sockless_interrupt_flags_r, sockless_set,
                                             sockless_clr);
    end
  end

  // plain read/write registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      socket_irq_mask_r <= RST_BYTE;
      sockless_irq_mask_r <= RST_BYTE;
      source_select_r <= RST_BYTE;
      mgmt_addr_r <= RST_HALF[PHY_ADDR_W-1:0];
      mgmt_wdata_r <= RST_HALF;
    end else if (ce) begin
      if (wr_to(ADDR_SOCKET_IRQ_MASK)) begin
        socket_irq_mask_r <= bus_wdata;
      end
      if (wr_to(ADDR_SOCKLESS_IRQ_MASK)) begin
        sockless_irq_mask_r <= bus_wdata;
      end
      if (wr_to(ADDR_SOURCE_SELECT)) begin
        source_select_r <= bus_wdata;
      end
      if (wr_to(ADDR_PHY_REG_ADDRESS)) begin
        mgmt_addr_r <= bus_wdata[PHY_ADDR_W-1:0];
      end
      if (wr_to(ADDR_PHY_WRITE_DATA_LO)) begin
        mgmt_wdata_r[7:0] <= bus_wdata;
      end
      if (wr_to(ADDR_PHY_WRITE_DATA_HI)) begin
        mgmt_wdata_r[15:8] <= bus_wdata;
      end
    end
  end

  // socket-less command: a write while busy is dropped, so software must poll for zero
  assign cmd_accept = wr_to(ADDR_SOCKLESS_COMMAND) && (cmd_state_r == SEQ_IDLE)
                      && |(bus_wdata & COMMAND_BITS);
  assign cmd_finish = (cmd_state_r == SEQ_BUSY) && cmd_done;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmd_state_r <= SEQ_IDLE;
      sockless_command_r <= RST_BYTE;
      cmd_go_r <= 1'b0;
    end else if (ce) begin
      cmd_go_r <= cmd_accept;
      unique case (cmd_state_r)
        SEQ_IDLE: begin
          if (cmd_accept) begin
            sockless_command_r <= bus_wdata & COMMAND_BITS;
            cmd_state_r <= SEQ_BUSY;
          end
        end
        SEQ_BUSY: begin
          if (cmd_done) begin
            sockless_command_r <= RST_BYTE;
            cmd_state_r <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // source address choice for socket-less ipv6 packets; unknown codes behave as auto
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      use_global_src_r <= 1'b0;
    end else if (ce) begin
      if (source_select_r == SRC_LINK_LOCAL) begin
        use_global_src_r <= 1'b0;
      end else if (source_select_r == SRC_GLOBAL) begin
        use_global_src_r <= 1'b1;
      end else begin
        use_global_src_r <= !dest_is_link_local;
      end
    end
  end

  // phy status pins come from the phy's own clock, so two flops first
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_meta_r <= RST_PINS;
      pin_sync_r <= RST_PINS;
    end else if (ce) begin
      pin_meta_r <= phy_pins;
      pin_sync_r <= pin_meta_r;
    end
  end

  // duplex and speed are meaningless with link down, so they read zero then
  assign phy_status = {pin_sync_r[PIN_UNPLUGGED], 1'b0, phy_mode,
                       pin_sync_r[PIN_LINK_UP] & pin_sync_r[PIN_HALF_DUPLEX],
                       pin_sync_r[PIN_LINK_UP] & pin_sync_r[PIN_SPEED10],
                       pin_sync_r[PIN_LINK_UP]};

  // indirect phy management access
  assign acc_accept = wr_to(ADDR_PHY_ACCESS_CONTROL) && (acc_state_r == SEQ_IDLE)
                      && ((bus_wdata == PHY_ACC_WRITE) || (bus_wdata == PHY_ACC_READ));
  assign acc_finish = (acc_state_r == SEQ_BUSY) && mgmt_done;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_state_r <= SEQ_IDLE;
      phy_access_control_r <= RST_BYTE;
      mgmt_go_r <= 1'b0;
      mgmt_write_r <= 1'b0;
    end else if (ce) begin
      mgmt_go_r <= acc_accept;
      unique case (acc_state_r)
        SEQ_IDLE: begin
          if (acc_accept) begin
            phy_access_control_r <= bus_wdata;
            mgmt_write_r <= (bus_wdata == PHY_ACC_WRITE);
            acc_state_r <= SEQ_BUSY;
          end
        end
        SEQ_BUSY: begin
          if (mgmt_done) begin
            phy_access_control_r <= RST_BYTE;
            acc_state_r <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      phy_read_data_r <= RST_HALF;
    end else if (ce && acc_finish && !mgmt_write_r) begin
      phy_read_data_r <= mgmt_rdata;
    end
  end

  // read mux; clear registers and unmapped addresses answer zero
  always_comb begin
    unique case (bus_addr)
      ADDR_SOCKET_IRQ_MASK: rd_nxt = socket_irq_mask_r;
      ADDR_SOCKLESS_IRQ_MASK: rd_nxt = sockless_irq_mask_r;
      ADDR_SOURCE_SELECT: rd_nxt = source_select_r;
      ADDR_SOCKLESS_COMMAND: rd_nxt = sockless_command_r;
      ADDR_PHY_STATUS: rd_nxt = phy_status;
      ADDR_PHY_REG_ADDRESS: rd_nxt = {3'h0, mgmt_addr_r};
      ADDR_PHY_WRITE_DATA_LO: rd_nxt = mgmt_wdata_r[7:0];
      ADDR_PHY_WRITE_DATA_HI: rd_nxt = mgmt_wdata_r[15:8];
      ADDR_PHY_READ_DATA_LO: rd_nxt = phy_read_data_r[7:0];
      ADDR_PHY_READ_DATA_HI: rd_nxt = phy_read_data_r[15:8];
      ADDR_PHY_ACCESS_CONTROL: rd_nxt = phy_access_control_r;
      default: rd_nxt = RST_BYTE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus_rdata_r <= RST_BYTE;
    end else if (ce && bus_rd) begin
      bus_rdata_r <= rd_nxt;
    end
  end

  // interrupt line lags the flags by one cycle to keep the output registered
  assign irq_nxt = |(common_interrupt_flags_r & common_irq_mask)
                   | |(socket_interrupt_summary & socket_irq_mask_r)
                   | |(sockless_interrupt_flags_r & sockless_irq_mask_r);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= irq_nxt;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_common_clear;
    ce && wr_to(ADDR_COMMON_IRQ_CLEAR) && bus_wdata[0] && !common_event[0]
      |=> !common_interrupt_flags_r[0];
  endproperty
  a_common_clear: assert property (p_common_clear)
    else $error("common flag not cleared by one written");

  property p_sockless_set_wins;
    ce && wr_to(ADDR_SOCKLESS_IRQ_CLEAR) && bus_wdata[0] && ra_received
      |=> sockless_interrupt_flags_r[0];
  endproperty
  a_sockless_set_wins: assert property (p_sockless_set_wins)
    else $error("event lost while clearing");

  property p_socket_mask_irq;
    ce && (|(socket_interrupt_summary & socket_irq_mask_r)) |=> irq_r;
  endproperty
  a_socket_mask_irq: assert property (p_socket_mask_irq)
    else $error("unmasked socket interrupt missing");

  property p_irq_quiet;
    ce && !irq_nxt |=> !irq_r;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt with no unmasked flag");

  property p_cmd_self_clear;
    ce && cmd_finish |=> sockless_command_r == RST_BYTE;
  endproperty
  a_cmd_self_clear: assert property (p_cmd_self_clear)
    else $error("command did not self-clear");

  property p_cmd_hold;
    (cmd_state_r == SEQ_BUSY) && !cmd_done && ce |=> $stable(sockless_command_r);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold)
    else $error("command changed while busy");

  property p_timeout_flag;
    ce && cmd_finish && !cmd_reply_ok |=> sockless_interrupt_flags_r[7];
  endproperty
  a_timeout_flag: assert property (p_timeout_flag)
    else $error("timeout flag not set");

  property p_src_link_local;
    ce && source_select_r == SRC_LINK_LOCAL |=> !use_global_src_r;
  endproperty
  a_src_link_local: assert property (p_src_link_local)
    else $error("link-local source not chosen");

  property p_status_link_down;
    !pin_sync_r[PIN_LINK_UP] |-> phy_status[2:0] == 3'h0;
  endproperty
  a_status_link_down: assert property (p_status_link_down)
    else $error("duplex or speed shown with link down");

  property p_access_clear;
    ce && acc_finish |=> phy_access_control_r == RST_BYTE;
  endproperty
  a_access_clear: assert property (p_access_clear)
    else $error("access control did not self-clear");

  // a finishing command may set the timeout bit again, so it is left out here
  property p_sockless_clear;
    ce && wr_to(ADDR_SOCKLESS_IRQ_CLEAR) && bus_wdata[7] && !cmd_finish
      |=> !sockless_interrupt_flags_r[7];
  endproperty
  a_sockless_clear: assert property (p_sockless_clear)
    else $error("socket-less flag not cleared by one written");

  property p_read_capture;
    ce && acc_finish && !mgmt_write_r |=> phy_read_data_r == $past(mgmt_rdata);
  endproperty
  a_read_capture: assert property (p_read_capture)
    else $error("phy read data not captured");

  property p_src_global;
    ce && source_select_r == SRC_GLOBAL |=> use_global_src_r;
  endproperty
  a_src_global: assert property (p_src_global)
    else $error("global source not chosen");

endmodule : irq_sockless_phy_regs

// [testbench/engine_model.sv]
// stand-in for the packet engine and phy management unit beside the register group
`timescale 1ns/1ps
module engine_model (
  input wire logic ref_clk,
  input wire logic cmd_go,
  input wire logic mgmt_go,
  input wire logic ok,
  input wire logic [3:0] lat,
  input wire logic [15:0] rval,
  output logic cmd_done,
  output logic cmd_reply_ok,
  output logic mgmt_done,
  output logic [15:0] mgmt_rdata
);
  initial begin
    cmd_done = 1'b0;
    cmd_reply_ok = 1'b0;
    mgmt_done = 1'b0;
    mgmt_rdata = 16'h0000;
  end
  // outcome only through done and its reply qualifier; lat 0 answers at once
  always @(posedge ref_clk) begin
    #1;
    if (cmd_go) begin
      repeat (lat) begin
        @(posedge ref_clk);
        #1;
      end
      cmd_done = 1'b1;
      cmd_reply_ok = ok;
      @(posedge ref_clk);
      #1 cmd_done = 1'b0;
      cmd_reply_ok = ~ok;
    end
  end
  // read value only valid with done, inverse otherwise so stale data is caught
  always @(posedge ref_clk) begin
    #1;
    if (mgmt_go) begin
      mgmt_rdata = ~rval;
      repeat (lat) begin
        @(posedge ref_clk);
        #1;
      end
      mgmt_done = 1'b1;
      mgmt_rdata = rval;
      @(posedge ref_clk);
      #1 mgmt_done = 1'b0;
      mgmt_rdata = ~rval;
    end
  end
endmodule : engine_model

// [testbench/tb_irq_sockless_phy_regs.sv]
// self-checking bench for the socket-less interrupt and phy register group
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %0t got %h exp %h", $time, (g), (e)); end end
module tb_irq_sockless_phy_regs
  import irq_phy_regs_pkg::*;
;
  logic ref_clk, rst_n, ce, bus_wr, bus_rd, cmd_done, cmd_reply_ok, ra_received, ok;
  logic dest_is_link_local, mgmt_done, cmd_go_r, use_global_src_r, mgmt_go_r;
  logic mgmt_write_r, irq_r, rd_taken;
  logic [15:0] bus_addr, mgmt_rdata, mgmt_wdata_r, rval, d16;
  logic [7:0] bus_wdata, bus_rdata_r, common_event, common_irq_mask, c, exp_sl, exp_rd;
  logic [7:0] socket_interrupt_summary, common_interrupt_flags_r;
  logic [7:0] sockless_interrupt_flags_r, sockless_command_r;
  logic [3:0] phy_pins, lat;
  logic [2:0] phy_mode;
  logic [PHY_ADDR_W-1:0] mgmt_addr_r;
  logic [7:0] expq[$];
  int miscompares = 0, total_checks = 0, cg_cnt = 0, mg_cnt = 0;
  localparam logic [15:0] RST_LIST [10] = '{ADDR_COMMON_IRQ_CLEAR, ADDR_SOCKET_IRQ_MASK,
    ADDR_SOCKLESS_IRQ_MASK, ADDR_SOCKLESS_IRQ_CLEAR, ADDR_SOURCE_SELECT,
    ADDR_SOCKLESS_COMMAND, ADDR_PHY_REG_ADDRESS, ADDR_PHY_WRITE_DATA_LO,
    ADDR_PHY_WRITE_DATA_HI, 16'h2200};
  localparam logic [7:0] SRCS [4] = '{SRC_AUTO, SRC_LINK_LOCAL, SRC_GLOBAL, 8'h01};

  irq_sockless_phy_regs dut (.ref_clk, .rst_n, .ce, .bus_addr, .bus_wr, .bus_wdata,
    .bus_rd, .bus_rdata_r, .common_event, .common_irq_mask, .socket_interrupt_summary,
    .cmd_done, .cmd_reply_ok, .ra_received, .dest_is_link_local, .phy_pins, .phy_mode,
    .mgmt_done, .mgmt_rdata, .common_interrupt_flags_r, .sockless_interrupt_flags_r,
    .sockless_command_r, .cmd_go_r, .use_global_src_r, .mgmt_go_r, .mgmt_write_r,
    .mgmt_addr_r, .mgmt_wdata_r, .irq_r);
  engine_model partner (.ref_clk, .cmd_go(cmd_go_r), .mgmt_go(mgmt_go_r), .ok, .lat,
    .rval, .cmd_done, .cmd_reply_ok, .mgmt_done, .mgmt_rdata);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // read data is compared half a cycle after the capturing edge, once it has settled
  always @(posedge ref_clk) rd_taken <= bus_rd && ce && rst_n;
  always @(negedge ref_clk) begin
    // pop once: the macro evaluates its expected argument twice on a mismatch
    if (rd_taken === 1'b1 && expq.size() > 0) begin
      exp_rd = expq.pop_front();
      `CHK(bus_rdata_r, exp_rd)
    end
    if (rst_n === 1'b1) begin
      cg_cnt += (cmd_go_r === 1'b1);
      mg_cnt += (mgmt_go_r === 1'b1);
    end
  end
  // the strobe drops for one idle cycle so back-to-back calls never reassign it at once
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge ref_clk);
    #1 bus_wr = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    expq.push_back(e);
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge ref_clk);
    #1 bus_rd = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic cmd(input logic [7:0] v);
    wr(ADDR_SOCKLESS_COMMAND, v);
    for (int k = 0; k < 20 && sockless_command_r !== 8'h00; k++) tick(1);
    tick(1);
  endtask : cmd
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    {bus_wr, bus_rd, ra_received, dest_is_link_local, ok} = 5'h00;
    {bus_addr, bus_wdata, common_event, common_irq_mask} = 40'h0;
    {socket_interrupt_summary, phy_pins, phy_mode, lat, rval} = 35'h0;
    exp_sl = 8'h00;
    void'($urandom(32'h0c65));
    repeat (20) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    foreach (RST_LIST[i]) rd(RST_LIST[i], RST_BYTE);
    c = 8'($urandom);
    wr(ADDR_SOCKET_IRQ_MASK, c);
    wr(ADDR_SOCKLESS_IRQ_MASK, ~c);
    rd(ADDR_SOCKLESS_IRQ_MASK, ~c);
    ce = 1'b0;
    wr(ADDR_SOCKET_IRQ_MASK, ~c);
    ce = 1'b1;
    rd(ADDR_SOCKET_IRQ_MASK, c);
    wr(ADDR_SOCKET_IRQ_MASK, 8'h00);
    wr(ADDR_SOCKLESS_IRQ_MASK, 8'h00);
    wr(ADDR_PHY_REG_ADDRESS, 8'hff);
    rd(ADDR_PHY_REG_ADDRESS, 8'h1f);
    `CHK(mgmt_addr_r, 5'h1f)
    d16 = 16'($urandom);
    wr(ADDR_PHY_WRITE_DATA_LO, d16[7:0]);
    wr(ADDR_PHY_WRITE_DATA_HI, d16[15:8]);
    rd(ADDR_PHY_WRITE_DATA_HI, d16[15:8]);
    `CHK(mgmt_wdata_r, d16)
    lat = 4'h3;
    wr(ADDR_PHY_ACCESS_CONTROL, PHY_ACC_WRITE);
    `CHK(mgmt_write_r, 1'b1)
    tick(6);
    rd(ADDR_PHY_ACCESS_CONTROL, 8'h00);
    rval = 16'($urandom);
    wr(ADDR_PHY_ACCESS_CONTROL, PHY_ACC_READ);
    `CHK(mgmt_write_r, 1'b0)
    tick(6);
    rd(ADDR_PHY_READ_DATA_LO, rval[7:0]);
    rd(ADDR_PHY_READ_DATA_HI, rval[15:8]);
    `CHK(mg_cnt, 2)
    for (int i = 0; i < 8; i++) begin
      phy_mode = i[2:0];
      phy_pins = (i == 7) ? 4'he : (4'($urandom) | 4'h1);
      tick(4);
      c = {phy_pins[3], 1'b0, phy_mode, phy_pins[2:0] & {3{phy_pins[0]}}};
      rd(ADDR_PHY_STATUS, c);
    end
    for (int i = 0; i < 8; i++) begin
      c = SRCS[i / 2];
      dest_is_link_local = i[0];
      wr(ADDR_SOURCE_SELECT, c);
      `CHK(use_global_src_r, (c == SRC_GLOBAL) || (c != SRC_LINK_LOCAL && !i[0]))
    end
    rd(ADDR_SOURCE_SELECT, 8'h01);
    ok = 1'b1;
    for (int b = 6; b >= 0; b--) begin
      lat = 4'(b);
      if (b == 6) begin
        wr(ADDR_SOCKLESS_COMMAND, 8'h40);
        wr(ADDR_SOCKLESS_COMMAND, 8'h20);
        `CHK(sockless_command_r, 8'h40)
      end
      cmd(8'h01 << b);
      exp_sl |= (8'h01 << b) & REPLY_COMMAND_BITS;
      `CHK(sockless_interrupt_flags_r, exp_sl)
      `CHK(sockless_command_r, 8'h00)
    end
    ok = 1'b0;
    cmd(8'h20);
    cmd(8'h80);
    exp_sl |= TIMEOUT_FLAG;
    `CHK(sockless_interrupt_flags_r, exp_sl)
    `CHK(cg_cnt, 8)
    `CHK(irq_r, 1'b0)
    wr(ADDR_SOCKLESS_IRQ_MASK, TIMEOUT_FLAG);
    `CHK(irq_r, 1'b1)
    wr(ADDR_SOCKLESS_IRQ_CLEAR, 8'h00);
    `CHK(sockless_interrupt_flags_r, exp_sl)
    wr(ADDR_SOCKLESS_IRQ_CLEAR, 8'h7f);
    `CHK(sockless_interrupt_flags_r, TIMEOUT_FLAG)
    wr(ADDR_SOCKLESS_IRQ_CLEAR, TIMEOUT_FLAG);
    tick(1);
    `CHK(irq_r, 1'b0)
    ra_received = 1'b1;
    tick(1);
    ra_received = 1'b0;
    tick(2);
    `CHK(sockless_interrupt_flags_r, RA_FLAG)
    `CHK(irq_r, 1'b0)
    wr(ADDR_SOCKLESS_IRQ_MASK, RA_FLAG);
    `CHK(irq_r, 1'b1)
    wr(ADDR_SOCKLESS_IRQ_CLEAR, 8'hff);
    common_event = 8'hff;
    tick(1);
    common_event = 8'h00;
    common_irq_mask = 8'h04;
    tick(2);
    `CHK(common_interrupt_flags_r, COMMON_FLAG_BITS)
    `CHK(irq_r, 1'b1)
    wr(ADDR_COMMON_IRQ_CLEAR, 8'h04);
    tick(1);
    `CHK(irq_r, 1'b0)
    common_event = 8'h01;
    fork
      wr(ADDR_COMMON_IRQ_CLEAR, 8'h01);
      begin
        @(posedge ref_clk);
        #1 common_event = 8'h00;
      end
    join
    `CHK(common_interrupt_flags_r, 8'h93)
    wr(ADDR_COMMON_IRQ_CLEAR, 8'hff);
    `CHK(common_interrupt_flags_r, 8'h00)
    c = 8'h01 << ($urandom % 8);
    wr(ADDR_SOCKET_IRQ_MASK, c);
    socket_interrupt_summary = ~c;
    tick(2);
    `CHK(irq_r, 1'b0)
    socket_interrupt_summary = c;
    tick(2);
    `CHK(irq_r, 1'b1)
    tick(2);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    `CHK(irq_r, 1'b0)
    `CHK(mgmt_addr_r, 5'h00)
    rd(ADDR_SOCKET_IRQ_MASK, RST_BYTE);
    tick(2);
    conclude();
  end
endmodule : tb_irq_sockless_phy_regs
